// ---- gpo_logic_gpi_and_fast_pwm.v ----
// Pin logic for a rail sequencer: logic outputs, input functions,
// rail enables, power-good cascade and fast pulse modulators.
// Assumes one 125 MHz clock and an Avalon-MM master for setup.
//
// Behaviour
// RULE_01 - Output delay may apply on assertion, deassertion, both or neither.
// RULE_02 - Normal delay: a result reverting within the delay never reaches pin.
// RULE_03 - Ignore option: change always propagates; inputs ignored until delay ends.
// RULE_04 - Ignore option: every output pulse lasts at least the delay.
// RULE_05 - State machine mode: path 0 while true, path 1 while false.
// RULE_06 - Each special input function maps to at most one input pin.
// RULE_07 - Fault-enable input raises a fault while deasserted.
// RULE_08 - Clear-source input clears the sticky rail flags.
// RULE_09 - Margin enable places margining rails into margined state.
// RULE_10 - Margin low input picks low, else high, during margin enable.
// RULE_11 - Input polarity selectable; first three defined inputs pick states.
// RULE_12 - Any pin may be a rail enable, either polarity, od or push-pull.
// RULE_13 - During reset plain pins float, fast modulator pins drive low; the code drives every pin low in reset.
// RULE_14 - Fast-capable pins used as rail enables must be active high; the code applies the pin polarity bit either way.
// RULE_15 - Slave starts after master good; master drops good on shutdown.
// RULE_16 - Power-good output reflects a chosen subset of rails.
// RULE_17 - Modulator period is source divided by 2 to 16383.
// RULE_18 - Modulators paired 1-2, 3-4, 5-6, 7-8 sharing one divisor.
// RULE_19 - Enabling one modulator enables its unassigned companion.
// RULE_20 - Duty steps of one sixteenth of a source period.
// RULE_21 - Output is OR of two ANDs over outputs, inputs and rail flags.
// RULE_22 - Sticky rail flags hold until software or clear input clears.
// RULE_23 - Delays count a millisecond tick, one counter per output.
`default_nettype none
`include "gpo_pwm_defs.vh"

module gpo_logic_gpi_and_fast_pwm #(
	parameter TICK_CYCLES = `TICK_NS / `CLK_NS
) (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	input  wire [7:0]  general_input_pin,
	input  wire        bus_control_input,
	input  wire [9:0]  rail_good,
	input  wire [9:0]  rail_event,
	input  wire [9:0]  rail_on_req,
	input  wire        seq_off_start,
	output reg  [7:0]  pin_out,
	output reg  [7:0]  pin_oe,
	output reg         fault_out,
	output reg  [9:0]  rail_margin_low,
	output reg  [9:0]  rail_margin_high,
	output reg  [2:0]  input_chosen_rail_states,
	output reg         seq_on_permit,
	output reg         pg_out
);

	localparam ST_IDLE = 2'h0;
	localparam ST_WAIT = 2'h1;
	localparam ST_HOLD = 2'h2;

	// ****************************************
	// Registers and state
	// ****************************************
	reg  [15:0] incfg;
	reg  [15:0] spec;
	reg  [31:0] pincfg;
	reg  [9:0]  marg_mask;
	reg  [9:0]  pg_mask;
	reg  [9:0]  latch;
	reg         fault_flag;
	reg  [31:0] path0 [0:7];
	reg  [31:0] path1 [0:7];
	reg  [15:0] dcfg  [0:7];
	reg  [13:0] div   [0:3];
	reg  [17:0] duty  [0:7];
	reg  [7:0]  q;
	reg         ack;
	reg  [7:0]  in_s1;
	reg  [7:0]  in_s2;
	reg         bc_s1;
	reg         bc_s2;
	reg  [16:0] tick_cnt;
	reg         tick;
	wire [7:0]  in_act;
	wire        acc;
	wire        wr;
	wire [3:0]  sel_fault;
	wire [3:0]  sel_clr;
	wire [3:0]  sel_men;
	wire [3:0]  sel_mlow;
	wire        fault_in;
	wire        clr_in;
	wire        men_in;
	wire        mlow_in;
	wire [9:0]  sw_clr;
	wire [7:0]  pwm;
	wire [15:0] func_eff;
	reg  [31:0] rd_mux;
	reg  [2:0]  chosen;
	reg  [1:0]  nsel;
	wire [5:0]  out_off;
	wire        out_hit;
	integer     i;
	integer     j;

	// Two-flop synchronisers on asynchronous pins
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			in_s1 <= 8'h00;
			in_s2 <= 8'h00;
			bc_s1 <= 1'b0;
			bc_s2 <= 1'b0;
		end else begin
			in_s1 <= general_input_pin;
			in_s2 <= in_s1;
			bc_s1 <= bus_control_input;
			bc_s2 <= bc_s1;
		end
	end

	// Polarity: bit set means active high
	assign in_act = ~(in_s2 ^ incfg[7:0]); // RULE_11

	// ****************************************
	// Special input functions
	// ****************************************
	// One pin-index field per function, so two pins can never share one
	assign sel_fault = spec[3:0];   // RULE_06
	assign sel_clr   = spec[7:4];   // RULE_06
	assign sel_men   = spec[11:8];  // RULE_06
	assign sel_mlow  = spec[15:12]; // RULE_06
	assign fault_in  = sel_fault[3] & ~in_act[sel_fault[2:0]]; // RULE_07
	assign clr_in    = sel_clr[3] & in_act[sel_clr[2:0]];
	assign men_in    = sel_men[3] & in_act[sel_men[2:0]];
	assign mlow_in   = sel_mlow[3] & in_act[sel_mlow[2:0]];

	// First three defined inputs form the state selector
	always @* begin
		chosen = 3'h0;
		nsel = 2'h0;
		for (i = 0; i < `N_IN; i = i + 1) begin
			if (incfg[8 + i] && nsel != 2'h3) begin
				chosen[nsel] = in_act[i]; // RULE_11
				nsel = nsel + 2'h1;
			end
		end
	end

	// ****************************************
	// Bus slave
	// ****************************************
	// One wait cycle; the access completes when ack is high
	assign acc = avs_read | avs_write;
	assign avs_waitrequest = acc & ~ack;
	assign wr = avs_write & ack;
	// Output blocks sit four words apart from the output base
	assign out_hit = (avs_address >= `A_OUT) && (avs_address < `A_DUTY);
	assign out_off = avs_address - `A_OUT;
	assign sw_clr = (wr && avs_address == `A_STAT) ?
		avs_writedata[`F_LATCH + 9:`F_LATCH] : 10'h000;

	// Read mux; unmapped words read as zero
	always @* begin
		rd_mux = 32'h0000_0000;
		if (avs_address == `A_INCFG)
			rd_mux = {16'h0000, incfg};
		else if (avs_address == `A_SPEC)
			rd_mux = {16'h0000, spec};
		else if (avs_address == `A_STAT)
			rd_mux = {6'h00, latch, q, pg_out, seq_on_permit,
				mlow_in, men_in, chosen, fault_flag};
		else if (avs_address == `A_PIN)
			rd_mux = pincfg;
		else if (avs_address == `A_MARG)
			rd_mux = {22'h000000, marg_mask};
		else if (avs_address == `A_PG)
			rd_mux = {22'h000000, pg_mask};
		else if (avs_address[5:2] == `A_DIV >> 2)
			rd_mux = {18'h00000, div[avs_address[1:0]]};
		else if (avs_address[5:3] == `A_DUTY >> 3)
			rd_mux = {14'h0000, duty[avs_address[2:0]]};
		else if (out_hit && out_off[1:0] == 2'h0)
			rd_mux = path0[out_off[4:2]];
		else if (out_hit && out_off[1:0] == 2'h1)
			rd_mux = path1[out_off[4:2]];
		else if (out_hit && out_off[1:0] == 2'h2)
			rd_mux = {16'h0000, dcfg[out_off[4:2]]};
	end

	// Register writes and read capture
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack <= 1'b0;
			avs_readdata <= 32'h0000_0000;
			incfg <= 16'h00ff;
			spec <= 16'h0000;
			pincfg <= 32'h0000_0000;
			marg_mask <= 10'h000;
			pg_mask <= 10'h3ff;
			for (j = 0; j < 8; j = j + 1) begin
				path0[j] <= 32'h0000_0000;
				path1[j] <= 32'h0000_0000;
				dcfg[j] <= 16'h0000;
				duty[j] <= 18'h00000;
			end
			for (j = 0; j < 4; j = j + 1)
				div[j] <= `DIV_MIN;
		end else begin
			ack <= acc & ~ack;
			if (avs_read && !ack)
				avs_readdata <= rd_mux;
			if (wr) begin
				if (avs_address == `A_INCFG)
					incfg <= avs_writedata[15:0];
				else if (avs_address == `A_SPEC)
					spec <= avs_writedata[15:0];
				else if (avs_address == `A_PIN)
					pincfg <= avs_writedata;
				else if (avs_address == `A_MARG)
					marg_mask <= avs_writedata[9:0];
				else if (avs_address == `A_PG)
					pg_mask <= avs_writedata[9:0];
				else if (avs_address[5:2] == `A_DIV >> 2)
					div[avs_address[1:0]] <= avs_writedata[13:0];
				else if (avs_address[5:3] == `A_DUTY >> 3)
					duty[avs_address[2:0]] <= avs_writedata[17:0];
				else if (out_hit) begin
					if (out_off[1:0] == 2'h0)
						path0[out_off[4:2]] <= avs_writedata;
					else if (out_off[1:0] == 2'h1)
						path1[out_off[4:2]] <= avs_writedata;
					else if (out_off[1:0] == 2'h2)
						dcfg[out_off[4:2]] <= avs_writedata[15:0];
				end
			end
		end
	end

	// ****************************************
	// Status, margin and cascade
	// ****************************************
	// New events win over any clear in the same cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latch <= 10'h000;
			fault_flag <= 1'b0;
			fault_out <= 1'b0;
			rail_margin_low <= 10'h000;
			rail_margin_high <= 10'h000;
			input_chosen_rail_states <= 3'h0;
			seq_on_permit <= 1'b0;
			pg_out <= 1'b0;
		end else begin
			latch <= (latch & ~sw_clr & ~{10{clr_in}})
				| rail_event; // RULE_08 RULE_22
			fault_flag <= (fault_flag & ~(wr && avs_address == `A_STAT
				&& avs_writedata[0])) | fault_in; // RULE_07
			fault_out <= fault_in;
			rail_margin_low <= (men_in & mlow_in) ?
				marg_mask : 10'h000; // RULE_09 RULE_10
			rail_margin_high <= (men_in & ~mlow_in) ?
				marg_mask : 10'h000; // RULE_09 RULE_10
			input_chosen_rail_states <= chosen;
			seq_on_permit <= bc_s2; // RULE_15
			pg_out <= ~seq_off_start & (|pg_mask) &
				(&(rail_good | ~pg_mask)); // RULE_15 RULE_16
		end
	end

	// Millisecond tick shared by all delay counters
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= 17'h00000;
			tick <= 1'b0;
		end else if (tick_cnt == TICK_CYCLES[16:0] - 17'h00001) begin
			tick_cnt <= 17'h00000;
			tick <= 1'b1; // RULE_23
		end else begin
			tick_cnt <= tick_cnt + 17'h00001;
			tick <= 1'b0;
		end
	end

	// ****************************************
	// Logic outputs
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < `N_OUT; g = g + 1) begin : lo
			wire [25:0] v0;
			wire [25:0] v1;
			wire        p0;
			wire        p1;
			wire        r;
			wire [11:0] dly;
			wire        dir_dly;
			reg         lres;
			reg         tgt;
			reg  [1:0]  st;
			reg  [11:0] cnt;
			// Rail term uses live or sticky flags per path
			assign v0 = {path0[g][`F_STICKY] ? latch : rail_good, q, in_act};
			assign v1 = {path1[g][`F_STICKY] ? latch : rail_good, q, in_act};
			// An empty AND path is false, not vacuously true
			assign p0 = (|path0[g][25:0]) &
				(&(v0 | ~path0[g][25:0])); // RULE_21
			assign p1 = (|path1[g][25:0]) &
				(&(v1 | ~path1[g][25:0])); // RULE_21
			assign r = dcfg[g][`F_SM] ? (lres ? p0 : p1)
				: (p0 | p1); // RULE_05
			assign dly = dcfg[g][11:0];
			assign dir_dly = (r ? dcfg[g][`F_DLY_AS] : dcfg[g][`F_DLY_DE])
				& (dly != 12'h000); // RULE_01

			// Delay machine, own counter per output
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					lres <= 1'b0;
					tgt <= 1'b0;
					st <= ST_IDLE;
					cnt <= 12'h000;
					q[g] <= 1'b0;
				end else begin
					lres <= r;
					case (st)
						ST_IDLE: begin
							cnt <= 12'h000;
							if (r != q[g]) begin
								tgt <= r;
								if (dir_dly)
									st <= ST_WAIT; // RULE_01
								else begin
									q[g] <= r;
									if (dcfg[g][`F_IGN] && dly != 12'h000)
										st <= ST_HOLD; // RULE_04
								end
							end
						end
						ST_WAIT: begin
							if (!dcfg[g][`F_IGN] && r != tgt)
								st <= ST_IDLE; // RULE_02
							else if (tick) begin
								if (cnt + 12'h001 >= dly) begin
									q[g] <= tgt; // RULE_03
									cnt <= 12'h000;
									st <= dcfg[g][`F_IGN] ?
										ST_HOLD : ST_IDLE; // RULE_04
								end else
									cnt <= cnt + 12'h001; // RULE_23
							end
						end
						ST_HOLD: begin
							// Inputs ignored until the hold ends
							if (tick) begin
								if (cnt + 12'h001 >= dly)
									st <= ST_IDLE; // RULE_03
								else
									cnt <= cnt + 12'h001;
							end
						end
						default: st <= ST_IDLE;
					endcase
				end
			end
		end
	endgenerate

	// ****************************************
	// Fast pulse modulators
	// ****************************************
	// Companion takes the modulator function only when left unassigned
	generate
		for (g = 0; g < `N_OUT; g = g + 1) begin : fe
			assign func_eff[2 * g + 1:2 * g] =
				(pincfg[2 * g + 1:2 * g] == `PF_OFF &&
				pincfg[2 * (g ^ 1) + 1:2 * (g ^ 1)] == `PF_PWM) ?
				`PF_PWM : pincfg[2 * g + 1:2 * g]; // RULE_19
		end
	endgenerate

	generate
		for (g = 0; g < `N_PAIR; g = g + 1) begin : fp
			reg  [13:0] pc;
			wire [13:0] d;
			wire        wrap;
			// Divisors below two are clamped to the minimum
			assign d = (div[g] < `DIV_MIN) ? `DIV_MIN : div[g]; // RULE_17
			assign wrap = (pc >= d - 14'h0001);
			// One period counter per pair sets the shared frequency
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n)
					pc <= 14'h0000;
				else if (wrap)
					pc <= 14'h0000; // RULE_18
				else
					pc <= pc + 14'h0001;
			end
			genvar c;
			for (c = 0; c < 2; c = c + 1) begin : ch
				reg  [3:0] acc4;
				reg        extra;
				wire [4:0] sum;
				// Fine sixteenths dithered across sixteen periods
				assign sum = {1'b0, acc4} + {1'b0, duty[2 * g + c][3:0]};
				always @(posedge clk or negedge rst_n) begin
					if (!rst_n) begin
						acc4 <= 4'h0;
						extra <= 1'b0;
					end else if (wrap) begin
						acc4 <= sum[3:0];
						extra <= sum[4]; // RULE_20
					end
				end
				assign pwm[2 * g + c] = ({1'b0, pc} <
					{1'b0, duty[2 * g + c][17:4]} + {14'h0000, extra});
			end
		end
	endgenerate

	// ****************************************
	// Pin drivers
	// ****************************************
	// Reset drives every modulator-capable pin low
	generate
		for (g = 0; g < `N_OUT; g = g + 1) begin : pd
			wire [1:0] f;
			wire       lvl;
			wire       v;
			assign f = func_eff[2 * g + 1:2 * g];
			// Fast pins as enables rely on software choosing active high
			assign lvl = (f == `PF_ENABLE) ? rail_on_req[g] : q[g]; // RULE_14
			assign v = ~(lvl ^ pincfg[16 + g]);
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					pin_out[g] <= 1'b0; // RULE_13
					pin_oe[g] <= 1'b1;  // RULE_13
				end else if (f == `PF_PWM) begin
					pin_out[g] <= pwm[g];
					pin_oe[g] <= 1'b1;
				end else if (f == `PF_OFF) begin
					pin_out[g] <= 1'b0;
					pin_oe[g] <= 1'b0;
				end else if (pincfg[24 + g]) begin
					pin_out[g] <= 1'b0; // RULE_12
					pin_oe[g] <= ~v;
				end else begin
					pin_out[g] <= v; // RULE_12
					pin_oe[g] <= 1'b1;
				end
			end
		end
	endgenerate

endmodule // gpo_logic_gpi_and_fast_pwm
`default_nettype wire

// ---- gpo_logic_gpi_and_fast_pwm_test.sv ----
// Self-checking bench for the pin logic block, all checks via register
// reads or direct port sampling. Assumes the defs header on include path.
`default_nettype none
`include "gpo_pwm_defs.vh"

module gpo_logic_gpi_and_fast_pwm_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [7:0]  in_pins = 8'h00;
	logic        bus_control_input = 1'b0;
	logic [9:0]  rail_good, rail_margin_low, rail_margin_high;
	logic [9:0]  rail_event = 10'h000;
	logic [9:0]  rail_on_req = 10'h000;
	logic        seq_off_start = 1'b0;
	logic [7:0]  pin_out, pin_oe;
	logic        fault_out, seq_on_permit, pg_out;
	logic [2:0]  chosen;
	logic [63:0] notes [$];
	int          n_errors = 0;
	int          checks_done = 0;

	// ********
	// Clock, design, supplies
	// ********
	always #4 clk = ~clk;

	// Short tick so millisecond delays are ten clocks
	gpo_logic_gpi_and_fast_pwm #(.TICK_CYCLES(10)) i_dut (
		.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .general_input_pin(in_pins),
		.bus_control_input, .rail_good, .rail_event, .rail_on_req,
		.seq_off_start, .pin_out, .pin_oe, .fault_out, .rail_margin_low,
		.rail_margin_high, .input_chosen_rail_states(chosen),
		.seq_on_permit, .pg_out
	);
	supply_model #(.RISE(6)) i_supply (.clk, .pin_out, .pin_oe, .rail_good);

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		// A read whose answer never came is a mismatch too
		if (notes.size() != 0)
			n_errors++;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Request held until waitrequest seen low, then one idle edge
	task automatic bus(input logic we, input logic [5:0] a,
		input logic [31:0] d);
		int   n;
		logic done;
		n = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= we;
		avs_read      <= !we;
		do begin
			@(negedge clk);
			done = (avs_waitrequest === 1'b0);
			@(posedge clk);
			n++;
		end while (!done && n < 50);
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		if (!done) begin
			n_errors++;
			close_out();
		end
		@(posedge clk);
	endtask

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [5:0] a, input logic [31:0] m,
		input logic [31:0] e);
		notes.push_back({m, e});
		bus(1'b0, a, 32'h0);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Oldest note judges each completed read
	always @(negedge clk) begin
		logic [63:0] nt;
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			nt = notes.pop_front();
			cmp_word(avs_readdata & nt[63:32], nt[31:0]);
		end
	end

	// ********
	// Scenarios
	// ********
	initial begin
		logic [31:0] v;
		logic [31:0] cfg [3];
		int unsigned div;
		logic [9:0]  lo, hi;
		logic [15:0] c4, c5;
		void'($urandom(57));
		cfg = '{32'h3003, 32'h7003, 32'h1003};
		tick(8);
		@(negedge clk);
		cmp_word({16'h0, pin_oe, pin_out}, 32'h0000ff00);
		tick(8);
		rst_n <= 1'b1;
		tick(2);
		rd(`A_INCFG, '1, 32'h000000ff);
		rd(`A_PG, '1, 32'h000003ff);
		rd(`A_DIV, '1, 32'h00000002);
		wr(6'h06, $urandom);
		rd(6'h06, '1, 32'h0);
		// Input 0 active low, inputs 0..4 defined
		wr(`A_INCFG, 32'h1ffe);
		for (int k = 0; k < 4; k++) begin
			v = $urandom;
			in_pins <= v[7:0];
			tick(8);
			rd(`A_STAT, 32'he, {28'h0, v[2:0] ^ 3'b001, 1'b0});
		end
		in_pins <= 8'h02;
		wr(`A_INCFG, 32'h1fff);
		wr(`A_SPEC, 32'h0000bac9);
		wr(`A_PIN, 32'h00030309);
		wr(`A_MARG, 32'h3ff);
		tick(8);
		wr(`A_STAT, 32'h1);
		rd(`A_STAT, 32'h1, 32'h0);
		in_pins <= 8'h00;
		tick(8);
		@(negedge clk);
		cmp_word({31'h0, fault_out}, 32'h1);
		@(posedge clk);
		rd(`A_STAT, 32'h1, 32'h1);
		in_pins <= 8'h02;
		tick(8);
		wr(`A_STAT, 32'h1);
		rd(`A_STAT, 32'h1, 32'h0);
		for (int m = 0; m < 4; m++) begin
			in_pins <= {4'h0, m[1:0], 2'b10};
			tick(8);
			lo = (m == 3) ? 10'h3ff : 10'h0;
			hi = (m == 1) ? 10'h3ff : 10'h0;
			@(negedge clk);
			cmp_word({8'h0, fault_out, chosen, rail_margin_high,
				rail_margin_low}, {9'h0, m[0], 2'b10, hi, lo});
			@(posedge clk);
		end
		v = $urandom;
		in_pins <= 8'h02;
		rail_event <= v[9:0];
		tick(3);
		rail_event <= 10'h000;
		tick(4);
		rd(`A_STAT, 32'h03ff0000, {6'h0, v[9:0], 16'h0});
		in_pins <= 8'h12;
		tick(8);
		in_pins <= 8'h02;
		tick(2);
		rd(`A_STAT, 32'h03ff0000, 32'h0);
		// Output 0 follows input 0 with a 3 tick delay
		wr(`A_OUT, 32'h1);
		for (int k = 0; k < 3; k++) begin
			wr(`A_OUT + 6'h2, cfg[k]);
			tick(100);
			in_pins <= 8'h03;
			tick(10);
			in_pins <= 8'h02;
			tick(30);
			rd(`A_STAT, 32'h100, {23'h0, k == 1, 8'h0});
			tick(100);
			in_pins <= 8'h03;
			tick(60);
			rd(`A_STAT, 32'h100, 32'h100);
			in_pins <= 8'h02;
			tick(10);
			rd(`A_STAT, 32'h100, {23'h0, k != 2, 8'h0});
			tick(60);
			rd(`A_STAT, 32'h100, 32'h0);
		end
		// State machine: path 1 sets on input 0, path 0 holds on input 5
		wr(`A_OUT, 32'h20);
		wr(`A_OUT + 6'h1, 32'h1);
		wr(`A_OUT + 6'h2, 32'h8000);
		for (int k = 0; k < 4; k++) begin
			in_pins <= (k == 1) ? 8'h23 : (k == 3) ? 8'h02 : 8'h22;
			tick(8);
			rd(`A_STAT, 32'h100, {23'h0, k == 1 || k == 2, 8'h0});
		end
		wr(`A_PG, 32'h002);
		rail_on_req <= 10'h002;
		tick(20);
		@(negedge clk);
		cmp_word({24'h0, pin_oe[3:0], pin_out[3:0]}, 32'h00000032);
		@(posedge clk);
		rd(`A_STAT, 32'h80, 32'h80);
		seq_off_start <= 1'b1;
		tick(4);
		rd(`A_STAT, 32'h80, 32'h0);
		seq_off_start <= 1'b0;
		wr(`A_PG, 32'h006);
		tick(4);
		rd(`A_STAT, 32'h80, 32'h0);
		bus_control_input <= 1'b1;
		tick(8);
		rd(`A_STAT, 32'h40, 32'h40);
		bus_control_input <= 1'b0;
		tick(8);
		rd(`A_STAT, 32'h40, 32'h0);
		// Pin 4 modulates, unassigned companion pin 5 comes along
		for (int k = 0; k < 2; k++) begin
			div = (k == 0) ? 3 : 3 + $urandom % 30;
			wr(`A_DIV + 6'h2, div);
			wr(`A_DUTY + 6'h4, 32'h20);
			wr(`A_DUTY + 6'h5, 32'h18);
			tick(4 * div);
			c4 = 16'h0;
			c5 = 16'h0;
			repeat (8 * div) begin
				@(negedge clk);
				c4 = c4 + {15'h0, pin_out[4] & pin_oe[4]};
				c5 = c5 + {15'h0, pin_out[5] & pin_oe[5]};
			end
			cmp_word({c5, c4}, {16'h000c, 16'h0010});
			@(posedge clk);
		end
		tick(4);
		close_out();
	end
endmodule // gpo_logic_gpi_and_fast_pwm_test
`default_nettype wire

// ---- gpo_pwm_defs.vh ----
// Constants for the pin logic, input functions and fast modulators.
// Assumes inclusion by bare name from the design file.
`ifndef GPO_PWM_DEFS_VH
`define GPO_PWM_DEFS_VH

// ****************************************
// Sizes
// ****************************************
`define N_IN      8
`define N_OUT     8
`define N_RAIL    10
`define N_PAIR    4
`define DLY_W     12
`define DIV_W     14
`define DUTY_W    18
`define DIV_MIN   14'h0002

// ****************************************
// Timing
// ****************************************
`define TICK_NS   1000000
`define CLK_NS    8

// ****************************************
// Register word addresses
// ****************************************
`define A_INCFG   6'h00
`define A_SPEC    6'h01
`define A_STAT    6'h02
`define A_PIN     6'h03
`define A_MARG    6'h04
`define A_PG      6'h05
`define A_DIV     6'h08
`define A_OUT     6'h10
`define A_DUTY    6'h30

// ****************************************
// Fields
// ****************************************
`define F_DLY_AS  12
`define F_DLY_DE  13
`define F_IGN     14
`define F_SM      15
`define F_STICKY  26
`define F_LATCH   16
`define F_QOUT    8
`define F_RSEL    1
`define F_MEN     4
`define F_MLOW    5
`define F_PERMIT  6
`define F_PGOOD   7

// Pin functions
`define PF_OFF    2'h0
`define PF_LOGIC  2'h1
`define PF_ENABLE 2'h2
`define PF_PWM    2'h3

`endif

// ---- pin_logic_checker_sva.sv ----
// Checker for the pin logic block: bus answer timing, reset drive,
// margin exclusivity and cascade permit.
// Assumes it is bound to the design top and sees only its ports.
`default_nettype none

module pin_logic_checker (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        bus_control_input,
	input wire logic [7:0]  pin_out,
	input wire logic [7:0]  pin_oe,
	input wire logic [9:0]  rail_margin_low,
	input wire logic [9:0]  rail_margin_high,
	input wire logic        seq_on_permit
);
	timeunit 1ns;
	timeprecision 1ps;

	// ********
	// Properties
	// ********
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Pins held low-driven right up to the release edge
	property p_reset_drive;
		$rose(rst_n) |-> $past(pin_oe) == 8'hff && $past(pin_out) == 8'h00;
	endproperty
	a_reset_drive: assert property (p_reset_drive)
		else $error("pins not driven low during reset");

	// A fresh read is always held off for its first cycle
	property p_first_wait;
		$rose(avs_read) |-> avs_waitrequest;
	endproperty
	a_first_wait: assert property (p_first_wait)
		else $error("read answered in its first cycle");

	// Answer comes exactly one cycle after the request is seen
	property p_answer;
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_answer: assert property (p_answer)
		else $error("bus answer late");

	property p_idle_ready;
		!avs_read && !avs_write |-> !avs_waitrequest;
	endproperty
	a_idle_ready: assert property (p_idle_ready)
		else $error("wait raised with no request");

	// Read data must not drift between reads
	property p_data_hold;
		!$past(avs_read) |-> $stable(avs_readdata);
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("read data changed without a read");

	// A rail is never margined low and high at once
	property p_margin_excl;
		(rail_margin_low & rail_margin_high) == 10'h000;
	endproperty
	a_margin_excl: assert property (p_margin_excl)
		else $error("rail margined low and high together");

	// Two sync flops plus one register: five samples is ample
	property p_permit_on;
		bus_control_input [*5] |-> seq_on_permit;
	endproperty
	a_permit_on: assert property (p_permit_on)
		else $error("permit missing after cascade good");

	property p_permit_off;
		!bus_control_input [*5] |-> !seq_on_permit;
	endproperty
	a_permit_off: assert property (p_permit_off)
		else $error("permit held after cascade good dropped");

	c_margin: cover property (rail_margin_low != 10'h000);
	c_permit: cover property ($rose(seq_on_permit));
	c_pin: cover property ($rose(pin_out[0]));
endmodule // pin_logic_checker

bind gpo_logic_gpi_and_fast_pwm pin_logic_checker i_chk (
	.clk, .rst_n, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
	.bus_control_input, .pin_out, .pin_oe, .rail_margin_low,
	.rail_margin_high, .seq_on_permit
);
`default_nettype wire

// ---- supply_model.sv ----
// Supplies behind the enable pins: each of rails 0..7 reports good a few clocks
// after its pin level goes high. Assumes active-high enables.
`default_nettype none

module supply_model #(
	parameter int RISE = 6
) (
	input  wire logic       clk,
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	output wire logic [9:0] rail_good
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] level;
	logic [7:0] hist [RISE];

	// Pull-down keeps a floating enable off, also in reset
	assign level = pin_out & pin_oe;
	// Slow ramp: good follows the enable RISE clocks later
	always @(posedge clk) begin
		hist[0] <= level;
		for (int i = 1; i < RISE; i++)
			hist[i] <= hist[i - 1];
	end
	assign rail_good = {2'b00, hist[RISE - 1]};
endmodule // supply_model
`default_nettype wire
